//--- pin_config_regs.vh
// pin_config_regs.vh: offsets, field positions, reset values for the memory-bus pin config
// assumes inclusion by the config block and its bench
`ifndef PIN_CONFIG_REGS_VH
`define PIN_CONFIG_REGS_VH

// ************************************************************
// register map
// ************************************************************
`define PINCFG_ADDR_CONFIG   12'h000
`define PINCFG_ADDR_STATUS   12'h004
`define PINCFG_RESET_VALUE   32'h00000000
`define PINCFG_WRITE_MASK    32'hEE0333F3

// ************************************************************
// field positions
// ************************************************************
`define PINCFG_READY3_INV    31
`define PINCFG_READY2_INV    30
`define PINCFG_READY1_INV    29
`define PINCFG_READY3_CLAIM  27
`define PINCFG_READY2_CLAIM  26
`define PINCFG_READY1_CLAIM  25
`define PINCFG_LEVEL_SENSE   17
`define PINCFG_RESET_CLAIM   16
`define PINCFG_WSTROBE_CLAIM 13
`define PINCFG_OE_CLAIM      12
`define PINCFG_BS1_CLAIM     9
`define PINCFG_BS0_CLAIM     8
`define PINCFG_CS3_CLAIM     7
`define PINCFG_CS0_CLAIM     4
`define PINCFG_DHI_CLAIM     1
`define PINCFG_DLO_CLAIM     0

`endif

//--- ready_sense.v
// ready_sense.v: conditions one ready input: inversion, then level or edge detect
// assumes the pin input is synchronous to pclk
`timescale 1ns/1ps
`default_nettype none

module ready_sense (
	input  wire pclk,
	input  wire presetn,
	input  wire pin_in,
	input  wire invert,
	input  wire claim,
	input  wire level_sense,
	output reg  ready_out
);

	// ************************************************************
	// polarity and detect
	// ************************************************************
	wire polar;
	reg  prev_reg;
	reg  ready_next;

	assign polar = pin_in ^ invert;

	always @* begin
		if (!claim)
			ready_next = 1'b0;
		else if (level_sense)
			ready_next = polar;
		else
			ready_next = polar & ~prev_reg;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg  <= 1'b0;
			ready_out <= 1'b0;
		end else begin
			prev_reg  <= polar;
			ready_out <= ready_next;
		end
	end

endmodule // ready_sense

`default_nettype wire

//--- ext_bus_pin_config.v
// ext_bus_pin_config.v: APB config register that hands memory-bus pins to the bus interface
// assumes an APB master on pclk; pins are synchronous inputs; pin muxes follow the claim outputs
// assumes disable mode arrives as a level from the system configuration
// assumes paddr is a byte address with one aligned word per register
//
// Contract
// - ready inversion bits 31, 30, 29
// - ready pin claim bits 27, 26, 25
// - bit 17 set level, clear edge
// - bit 16 claims memory reset pin
// - bit 13 claims write strobe pin
// - disable mode frees all pins
// - unimplemented bits read zero, ignore writes
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pin_config_regs.vh"

module ext_bus_pin_config (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	input  wire        membus_disable_mode,
	input  wire        ready_in1,
	input  wire        ready_in2,
	input  wire        ready_in3,
	output wire [3:1]  ready_to_bus,
	output reg  [3:1]  ready_pin_claim,
	output reg         mem_reset_pin_claim,
	output reg         write_strobe_pin_claim,
	output reg         output_enable_pin_claim,
	output reg  [1:0]  byte_select_pin_claim,
	output reg  [3:0]  chip_select_pin_claim,
	output reg         data_high_lane_claim,
	output reg         data_low_lane_claim
);

	// ************************************************************
	// address decode
	// ************************************************************
	// one aligned word per register; every other address is refused
	function addr_hit(
		input [11:0] addr,
		input [11:0] target
	);
		addr_hit = (addr == target);
	endfunction

	// ************************************************************
	// bus decode
	// ************************************************************
	wire        access;
	wire        setup_read;
	wire        write_cfg;
	wire        hit_cfg;
	wire        hit_stat;

	assign access     = psel & penable;
	assign setup_read = psel & ~penable & ~pwrite;
	assign hit_cfg    = addr_hit(paddr, `PINCFG_ADDR_CONFIG);
	assign hit_stat   = addr_hit(paddr, `PINCFG_ADDR_STATUS);
	assign write_cfg  = access & pwrite & hit_cfg;
	assign pready     = 1'b1;
	// status is read-only, so a write to it is refused like a stray address
	assign pslverr    = access & ~hit_cfg & ~(hit_stat & ~pwrite);

	// ************************************************************
	// config register
	// ************************************************************
	reg  [31:0] config_reg;
	reg  [31:0] config_next;

	// unimplemented positions never store, so they read back as zero
	always @* begin
		config_next = config_reg;
		if (write_cfg)
			config_next = pwdata & `PINCFG_WRITE_MASK;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			config_reg <= `PINCFG_RESET_VALUE;
		else
			config_reg <= config_next;
	end

	// ************************************************************
	// effective claims
	// ************************************************************
	// disable mode masks every field, so all pins fall back to general use
	wire [31:0] eff;
	assign eff = membus_disable_mode ? 32'h00000000 : config_reg;

	reg  [3:1]  ready_pin_claim_next;
	reg         mem_reset_pin_claim_next;
	reg         write_strobe_pin_claim_next;
	reg         output_enable_pin_claim_next;
	reg  [1:0]  byte_select_pin_claim_next;
	reg  [3:0]  chip_select_pin_claim_next;
	reg         data_high_lane_claim_next;
	reg         data_low_lane_claim_next;

	always @* begin
		ready_pin_claim_next         = {eff[`PINCFG_READY3_CLAIM], eff[`PINCFG_READY2_CLAIM],
			eff[`PINCFG_READY1_CLAIM]};
		mem_reset_pin_claim_next     = eff[`PINCFG_RESET_CLAIM];
		write_strobe_pin_claim_next  = eff[`PINCFG_WSTROBE_CLAIM];
		output_enable_pin_claim_next = eff[`PINCFG_OE_CLAIM];
		byte_select_pin_claim_next   = eff[`PINCFG_BS1_CLAIM:`PINCFG_BS0_CLAIM];
		chip_select_pin_claim_next   = eff[`PINCFG_CS3_CLAIM:`PINCFG_CS0_CLAIM];
		data_high_lane_claim_next    = eff[`PINCFG_DHI_CLAIM];
		data_low_lane_claim_next     = eff[`PINCFG_DLO_CLAIM];
	end

	// claims are registered so the pin muxes never see a decode glitch
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_pin_claim         <= 3'h0;
			mem_reset_pin_claim     <= 1'b0;
			write_strobe_pin_claim  <= 1'b0;
			output_enable_pin_claim <= 1'b0;
			byte_select_pin_claim   <= 2'h0;
			chip_select_pin_claim   <= 4'h0;
			data_high_lane_claim    <= 1'b0;
			data_low_lane_claim     <= 1'b0;
		end else begin
			ready_pin_claim         <= ready_pin_claim_next;
			mem_reset_pin_claim     <= mem_reset_pin_claim_next;
			write_strobe_pin_claim  <= write_strobe_pin_claim_next;
			output_enable_pin_claim <= output_enable_pin_claim_next;
			byte_select_pin_claim   <= byte_select_pin_claim_next;
			chip_select_pin_claim   <= chip_select_pin_claim_next;
			data_high_lane_claim    <= data_high_lane_claim_next;
			data_low_lane_claim     <= data_low_lane_claim_next;
		end
	end

	// ************************************************************
	// ready conditioning
	// ************************************************************
	wire [3:1]  ready_invert;
	wire [3:1]  ready_claim;
	wire        ready_level_sense;

	assign ready_invert      = {eff[`PINCFG_READY3_INV], eff[`PINCFG_READY2_INV],
		eff[`PINCFG_READY1_INV]};
	assign ready_claim       = ready_pin_claim_next;
	assign ready_level_sense = eff[`PINCFG_LEVEL_SENSE];

	// edge history runs while unclaimed, so a new claim on a pin that is
	// already high does not turn into a false ready pulse
	ready_sense u_ready1 (
		.pclk        (pclk),
		.presetn     (presetn),
		.pin_in      (ready_in1),
		.invert      (ready_invert[1]),
		.claim       (ready_claim[1]),
		.level_sense (ready_level_sense),
		.ready_out   (ready_to_bus[1])
	);

	ready_sense u_ready2 (
		.pclk        (pclk),
		.presetn     (presetn),
		.pin_in      (ready_in2),
		.invert      (ready_invert[2]),
		.claim       (ready_claim[2]),
		.level_sense (ready_level_sense),
		.ready_out   (ready_to_bus[2])
	);

	ready_sense u_ready3 (
		.pclk        (pclk),
		.presetn     (presetn),
		.pin_in      (ready_in3),
		.invert      (ready_invert[3]),
		.claim       (ready_claim[3]),
		.level_sense (ready_level_sense),
		.ready_out   (ready_to_bus[3])
	);

	// ************************************************************
	// read data
	// ************************************************************
	wire [31:0] status_word;
	reg  [31:0] read_word;
	reg  [31:0] prdata_next;

	assign status_word = {29'h00000000, ready_to_bus};

	// stray reads return zero alongside the error response
	always @* begin
		if (hit_cfg)
			read_word = config_reg;
		else if (hit_stat)
			read_word = status_word;
		else
			read_word = 32'h00000000;
	end

	// captured in the setup cycle, held until the next read setup
	always @* begin
		prdata_next = prdata;
		if (setup_read)
			prdata_next = read_word;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h00000000;
		else
			prdata <= prdata_next;
	end

endmodule // ext_bus_pin_config

`default_nettype wire

//--- ext_bus_pin_config_props.sv
// ext_bus_pin_config_props.sv: port assertions for the pin config block
// assumes a bind into ext_bus_pin_config
`timescale 1ns/1ps
`default_nettype none
`include "pin_config_regs.vh"
module ext_bus_pin_config_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pslverr,
	input wire logic        membus_disable_mode,
	input wire logic        mem_reset_pin_claim,
	input wire logic        write_strobe_pin_claim,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic [3:1]  ready_to_bus,
	input wire logic [3:1]  ready_pin_claim,
	input wire logic [3:0]  chip_select_pin_claim
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
wire       acc = psel && penable;
wire       cfg = acc && paddr == `PINCFG_ADDR_CONFIG;
wire [8:0] cl  = {ready_pin_claim, mem_reset_pin_claim, write_strobe_pin_claim,
	chip_select_pin_claim};
a_disable_frees: assert property (membus_disable_mode |=> !cl && !ready_to_bus)
	else $error("pins kept in disable mode");
a_claim_follows: assert property (cfg && pwrite ##1 !membus_disable_mode |=>
	cl == {$past(pwdata[27:25], 2), $past(pwdata[16], 2), $past(pwdata[13], 2),
	$past(pwdata[7:4], 2)}) else $error("claims differ from written word");
a_unused_zero: assert property (cfg && !pwrite |-> !(prdata & ~`PINCFG_WRITE_MASK))
	else $error("unimplemented bit read as one");
a_ready_gated: assert property (!(ready_to_bus & ~ready_pin_claim))
	else $error("ready passed on unclaimed pin");
a_config_ok: assert property (cfg |-> !pslverr)
	else $error("error on config access");
a_unmapped_err: assert property (acc && paddr != 12'h000 && paddr != 12'h004 |-> pslverr)
	else $error("no error on unmapped access");
a_status_werr: assert property (acc && pwrite && paddr == `PINCFG_ADDR_STATUS |-> pslverr)
	else $error("no error on status write");
a_reset_zero: assert property ($rose(presetn) |-> !cl)
	else $error("claims not zero after reset");
endmodule // ext_bus_pin_config_props
bind ext_bus_pin_config ext_bus_pin_config_props i_ext_bus_pin_config_props (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pslverr(pslverr),
	.membus_disable_mode(membus_disable_mode), .mem_reset_pin_claim(mem_reset_pin_claim),
	.write_strobe_pin_claim(write_strobe_pin_claim), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .ready_to_bus(ready_to_bus), .ready_pin_claim(ready_pin_claim),
	.chip_select_pin_claim(chip_select_pin_claim));
`default_nettype wire

//--- mem_ready_model.sv
// mem_ready_model.sv: external memories driving the three ready pins
// assumes the bench names the pin levels wanted
`timescale 1ns/1ps
`default_nettype none
module mem_ready_model (
	input  wire logic       pclk,
	input  wire logic [3:1] want,
	output var  logic [3:1] ready = 3'h0
);
always @(posedge pclk) ready <= want;
endmodule // mem_ready_model
`default_nettype wire

//--- ext_bus_pin_config_tb_top.sv
// ext_bus_pin_config_tb_top.sv: self-checking bench for the pin config block
// assumes design, checker and ready pin model compiled before
`timescale 1ns/1ps
`default_nettype none
`include "pin_config_regs.vh"
module ext_bus_pin_config_tb_top;
logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, dm = 0;
logic [11:0] paddr = 0;
logic [31:0] pwdata = 0, rnd = 32'h00000014;
logic [32:0] q[$];
logic [3:1]  want = 0;
wire  [3:1]  pins, rtb, rpc;
wire  [31:0] prdata;
wire         pready, pslverr, rp, wp, oe, dh, dl;
wire  [3:0]  cs;
wire  [1:0]  bs;
int          error_cnt = 0, samples_checked = 0;
initial forever #5 pclk = ~pclk;
mem_ready_model i_mem_ready_model (.pclk(pclk), .want(want), .ready(pins));
ext_bus_pin_config i_ext_bus_pin_config (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .prdata(prdata), .membus_disable_mode(dm), .ready_in1(pins[1]),
	.ready_in2(pins[2]), .ready_in3(pins[3]), .ready_to_bus(rtb), .ready_pin_claim(rpc),
	.mem_reset_pin_claim(rp), .write_strobe_pin_claim(wp), .output_enable_pin_claim(oe),
	.byte_select_pin_claim(bs), .chip_select_pin_claim(cs), .data_high_lane_claim(dh),
	.data_low_lane_claim(dl));
task automatic check(input logic [32:0] seen, input logic [32:0] exp);
	samples_checked++;
	if (seen !== exp) begin
		error_cnt++;
		$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
	end
endtask
task automatic conclude;
	if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
	else $display("STATUS NOT OK");
	$finish;
endtask
function automatic logic [31:0] xs(input logic [31:0] v);
	v ^= v << 13;
	v ^= v >> 17;
	return v ^ (v << 5);
endfunction
task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
	input logic [32:0] e);
	@(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
	q.push_back(e);
	@(posedge pclk) penable <= 1;
	do @(posedge pclk); while (pready !== 1'b1);
	{psel, penable} <= 2'b00;
endtask
always @(posedge pclk) if (psel && penable && pready)
	check({pslverr, pwrite ? 32'h0 : prdata}, q.pop_front());
initial begin
	repeat (10) @(posedge pclk);
	presetn <= 1;
	apb(0, `PINCFG_ADDR_CONFIG, 0, 0);
	apb(0, 12'h008, 0, 33'h100000000);
	apb(1, `PINCFG_ADDR_STATUS, 32'hFFFFFFFF, 33'h100000000);
	for (int i = 0; i < 8; i++) begin
		rnd = xs(rnd);
		dm <= i[0];
		apb(1, 0, rnd, 0);
		apb(0, 0, 0, {1'b0, rnd & `PINCFG_WRITE_MASK});
		check({rpc, rp, wp, oe, bs, cs, dh, dl},
			{rnd[27:25], rnd[16], rnd[13:12], rnd[9:4], rnd[1:0]} & {14{!i[0]}});
	end
	dm <= 0;
	apb(1, 0, {rnd[31:29], 12'h701, 17'h0}, 0);
	for (int i = 0; i < 8; i++) begin
		@(posedge pclk) want <= i[2:0];
		repeat (2) @(posedge pclk);
		#1 check({30'h0, rtb}, {30'h0, i[2:0] ^ rnd[31:29]});
		apb(0, `PINCFG_ADDR_STATUS, 0, {30'h0, i[2:0] ^ rnd[31:29]});
	end
	@(posedge pclk) want <= 0;
	apb(1, 0, 32'h0E000000, 0);
	@(posedge pclk) want <= 3'h7;
	repeat (2) @(posedge pclk);
	#1 check({30'h0, rtb}, 33'h7);
	@(posedge pclk) #1 check({30'h0, rtb}, 33'h0);
	conclude();
end
initial begin
	#100000;
	error_cnt++;
	conclude();
end
endmodule // ext_bus_pin_config_tb_top
`default_nettype wire
